// [rdd_pkg.sv]
package rdd_pkg;
  // Command block layout
  localparam int          CDB_LEN        = 10;
  localparam logic [3:0]  CDB_OPC_IDX    = 4'h0;
  localparam logic [3:0]  CDB_SEL_IDX    = 4'h2;
  localparam logic [3:0]  CDB_ALEN_HI    = 4'h7;
  localparam logic [3:0]  CDB_ALEN_LO    = 4'h8;
  localparam logic [7:0]  OPC_READ_DEFECT = 8'h37;
  localparam int          PLIST_BIT      = 4;
  localparam int          GLIST_BIT      = 3;
  localparam int          FMT_MSB        = 2;
  // Descriptor formats
  localparam logic [2:0]  FMT_BLOCK      = 3'h0;
  localparam logic [2:0]  FMT_BFI        = 3'h4;
  localparam logic [2:0]  FMT_PHYS       = 3'h5;
  localparam logic [15:0] HDR_LEN        = 16'h0004;
  localparam logic [15:0] SHORT_DESC     = 16'h0004;
  localparam logic [15:0] LONG_DESC      = 16'h0008;
  // Status and sense
  localparam logic [7:0]  ST_GOOD        = 8'h00;
  localparam logic [7:0]  ST_CHECK       = 8'h02;
  localparam logic [3:0]  SK_NO_SENSE    = 4'h0;
  localparam logic [3:0]  SK_RECOVERED   = 4'h1;
  localparam logic [3:0]  SK_MEDIUM_ERR  = 4'h3;
  localparam logic [3:0]  SK_ILLEGAL     = 4'h5;
  localparam logic [7:0]  ASC_NONE       = 8'h00;
  localparam logic [7:0]  ASC_DEFECT_NF  = 8'h1c;
  localparam logic [7:0]  ASC_BAD_OPC    = 8'h20;

  typedef enum {
    RD_IDLE,
    RD_CDB,
    RD_HDR,
    RD_LIST,
    RD_STATUS
  } rdd_state_t;
endpackage : rdd_pkg

// [rdd_readback.sv]
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [R1] Ten-byte command; byte 2 holds select bits and format, bytes 7-8 allocation length.
// [R2] No defect data reachable: check condition, medium error or no sense.
// [R3] Primary select set includes primary list, clear leaves it out.
// [R4] Grown select set includes grown list, clear leaves it out.
// [R5] Both selects set: both lists sent, primary first, not merged.
// [R6] Both selects clear: only the four-byte header is sent.
// [R7] Unsupported requested format falls back to the default format.
// [R8] Format mismatch: transfer data, then check condition with recovered error.
// [R9] Returned data starts with a four-byte header, then descriptors.
// [R10] Header primary flag set exactly when the primary list is returned.
// [R11] Header grown flag set exactly when the grown list is returned.
// [R12] Header format field reports the format actually used.
// [R13] List length is the descriptor byte total of the returned lists.
// [R14] Truncation keeps the full length and raises no check condition.
// [R15] Initiator compares reported length to allocation length for partial lists.
// [R16] Initiator may send allocation length four to read only the header.
// [R17] Bytes-from-index descriptors form a complete list, beyond capacity too.
// [R18] Block format contents are store-defined; physical coverage may vary.
// [R19] Initiators should avoid requesting the block format.
// [R20] Descriptors go in store order; count is length over descriptor size.
// [R21] Bytes sent never exceed the lesser of allocation and list total.
module rdd_readback (
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  // Command bytes from the bus front end
  input  wire logic               cdb_valid_i,
  input  wire logic [7:0]         cdb_byte_i,
  output logic                    cdb_ready_o,
  // Defect store
  input  wire logic               store_avail_i,
  input  wire logic               store_fault_i,
  input  wire logic               fmt_bfi_ok_i,
  input  wire logic               fmt_phys_ok_i,
  input  wire logic               fmt_block_ok_i,
  input  wire logic [2:0]         fmt_default_i,
  input  wire logic [15:0]        plist_bytes_i,
  input  wire logic [15:0]        glist_bytes_i,
  output logic                    store_rd_o,
  output logic                    store_glist_o,
  output logic [2:0]              store_fmt_o,
  output logic [15:0]             store_addr_o,
  input  wire logic [7:0]         store_data_i,
  // Data-in stream
  output logic                    din_valid_o,
  output logic [7:0]              din_data_o,
  input  wire logic               din_ready_i,
  // Completion
  output logic                    done_o,
  output logic [7:0]              status_o,
  output logic [3:0]              sense_key_o,
  output logic [7:0]              sense_asc_o
);
  import rdd_pkg::*;

  typedef struct packed {
    rdd_state_t  st;
    logic [3:0]  idx;
    logic [7:0]  opc;
    logic        plist;
    logic        glist;
    logic [2:0]  req_fmt;
    logic [2:0]  ret_fmt;
    logic [15:0] alen;
    logic [15:0] list_len;
    logic [15:0] sent;
    logic [15:0] limit;
    logic [15:0] pos;
    logic        in_glist;
    logic        rd_pend;
    logic        dval;
    logic [7:0]  data;
    logic        done;
    logic [7:0]  status;
    logic [3:0]  skey;
    logic [7:0]  asc;
  } rdd_regs_t;

  rdd_regs_t st_r;
  rdd_regs_t st_nxt;

  // Two-flop synchronisers for the store's status levels
  logic [1:0] avail_s_r;
  logic [1:0] fault_s_r;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      avail_s_r <= 2'h0;
      fault_s_r <= 2'h0;
    end else begin
      avail_s_r <= {avail_s_r[0], store_avail_i};
      fault_s_r <= {fault_s_r[0], store_fault_i};
    end
  end
  wire logic avail = avail_s_r[1];
  wire logic fault = fault_s_r[1];

  logic        fmt_ok;
  logic [2:0]  use_fmt;
  logic [15:0] total;
  logic [15:0] hdr_plus;
  logic [7:0]  hdr_byte;
  logic        take;
  logic        plist_sel;
  logic        glist_sel;

  always_comb begin
    case (st_r.req_fmt)
      FMT_BFI:   fmt_ok = fmt_bfi_ok_i;
      FMT_PHYS:  fmt_ok = fmt_phys_ok_i;
      FMT_BLOCK: fmt_ok = fmt_block_ok_i;
      default:   fmt_ok = 1'b0;
    endcase
  end
  assign use_fmt   = fmt_ok ? st_r.req_fmt : fmt_default_i; // [R7]
  assign plist_sel = st_r.plist;
  assign glist_sel = st_r.glist;
  // Descriptor bytes of the selected lists; zero when neither is selected
  assign total     = (plist_sel ? plist_bytes_i : 16'h0000)
                   + (glist_sel ? glist_bytes_i : 16'h0000); // [R3] [R4] [R6] [R13]
  assign hdr_plus  = st_r.list_len + HDR_LEN; // [R9]
  assign take      = st_r.dval & din_ready_i;

  always_comb begin
    case (st_r.sent[1:0])
      2'h0:    hdr_byte = 8'h00;
      2'h1:    hdr_byte = {3'h0, st_r.plist, st_r.glist, st_r.ret_fmt}; // [R10] [R11] [R12]
      2'h2:    hdr_byte = st_r.list_len[15:8]; // [R14]
      default: hdr_byte = st_r.list_len[7:0];
    endcase
  end

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (take) begin
      st_nxt.dval = 1'b0;
      st_nxt.sent = st_r.sent + 16'h0001;
    end
    case (st_r.st)
      RD_IDLE: begin
        st_nxt.idx = 4'h0;
        if (cdb_valid_i) begin
          st_nxt.st  = RD_CDB;
          st_nxt.opc = cdb_byte_i;
          st_nxt.idx = 4'h1;
        end
      end
      RD_CDB: begin
        if (cdb_valid_i) begin
          st_nxt.idx = st_r.idx + 4'h1;
          if (st_r.idx == CDB_SEL_IDX) begin // [R1]
            st_nxt.plist   = cdb_byte_i[PLIST_BIT];
            st_nxt.glist   = cdb_byte_i[GLIST_BIT];
            st_nxt.req_fmt = cdb_byte_i[FMT_MSB:0];
          end
          if (st_r.idx == CDB_ALEN_HI) begin
            st_nxt.alen[15:8] = cdb_byte_i;
          end
          if (st_r.idx == CDB_ALEN_LO) begin
            st_nxt.alen[7:0] = cdb_byte_i;
          end
          if (st_r.idx == 4'(CDB_LEN - 1)) begin
            st_nxt.sent  = 16'h0000;
            st_nxt.pos   = 16'h0000;
            st_nxt.skey  = SK_NO_SENSE;
            st_nxt.asc   = ASC_NONE;
            st_nxt.status = ST_GOOD;
            if (st_r.opc != OPC_READ_DEFECT) begin
              st_nxt.status = ST_CHECK;
              st_nxt.skey   = SK_ILLEGAL;
              st_nxt.asc    = ASC_BAD_OPC;
              st_nxt.st     = RD_STATUS;
            end else if (!avail || fault) begin // [R2]
              st_nxt.status = ST_CHECK;
              st_nxt.skey   = fault ? SK_MEDIUM_ERR : SK_NO_SENSE;
              st_nxt.asc    = ASC_DEFECT_NF;
              st_nxt.st     = RD_STATUS;
            end else begin
              st_nxt.st = RD_HDR;
            end
          end
        end
      end
      RD_HDR: begin
        // Latch format and length once select bits are settled
        if (st_r.sent == 16'h0000 && !st_r.dval && st_r.pos == 16'h0000) begin
          st_nxt.ret_fmt  = use_fmt; // [R12]
          st_nxt.list_len = total; // [R13]
          st_nxt.in_glist = !plist_sel; // [R5]
          st_nxt.pos      = 16'h0001;
        end else if (!st_r.dval || take) begin
          // Header (4) plus descriptors, clipped to allocation length
          st_nxt.limit = (st_r.alen < hdr_plus) ? st_r.alen : hdr_plus; // [R21]
          if (st_nxt.sent >= ((st_r.alen < hdr_plus) ? st_r.alen : hdr_plus)) begin
            st_nxt.st = RD_STATUS;
          end else if (st_nxt.sent < HDR_LEN) begin
            st_nxt.dval = 1'b1;
          end else begin
            st_nxt.pos = 16'h0000;
            st_nxt.st  = RD_LIST;
          end
        end
      end
      RD_LIST: begin
        st_nxt.rd_pend = 1'b0;
        if (st_r.rd_pend) begin
          st_nxt.dval = 1'b1;
          st_nxt.data = store_data_i;
          st_nxt.pos  = st_r.pos + 16'h0001;
        end else if (!st_r.dval || take) begin
          if (st_nxt.sent >= st_r.limit) begin // [R14] [R21]
            st_nxt.st = RD_STATUS;
          end else if (!st_r.in_glist && st_r.pos == plist_bytes_i) begin
            st_nxt.in_glist = 1'b1; // [R5]
            st_nxt.pos      = 16'h0000;
          end else begin
            st_nxt.rd_pend = 1'b1; // [R17] [R18] [R20]
          end
        end
      end
      RD_STATUS: begin
        if (!st_r.dval) begin
          if (st_r.opc == OPC_READ_DEFECT && st_r.status == ST_GOOD
              && st_r.ret_fmt != st_r.req_fmt) begin // [R8]
            st_nxt.status = ST_CHECK;
            st_nxt.skey   = SK_RECOVERED;
            st_nxt.asc    = ASC_DEFECT_NF;
          end
          st_nxt.done = 1'b1;
          st_nxt.st   = RD_IDLE;
        end
      end
      default: st_nxt.st = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.st <= RD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cdb_ready_o   = (st_r.st == RD_IDLE) || (st_r.st == RD_CDB);
  assign store_rd_o    = (st_r.st == RD_LIST) && st_r.rd_pend;
  assign store_glist_o = st_r.in_glist;
  assign store_fmt_o   = st_r.ret_fmt;
  assign store_addr_o  = st_r.pos;
  assign din_valid_o   = st_r.dval;
  assign din_data_o    = (st_r.st == RD_HDR) ? hdr_byte : st_r.data;
  assign done_o        = st_r.done;
  assign status_o      = st_r.status;
  assign sense_key_o   = st_r.skey;
  assign sense_asc_o   = st_r.asc;

  // Checks
  property p_no_overrun;
    @(posedge clock_i) disable iff (sys_rst_i)
      take |-> (st_r.sent < st_r.alen);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("sent past allocation"); // [R21]

  property p_trunc_good;
    @(posedge clock_i) disable iff (sys_rst_i)
      (done_o && st_r.ret_fmt == st_r.req_fmt && st_r.sent != 16'h0000)
        |-> status_o == ST_GOOD;
  endproperty
  a_trunc_good: assert property (p_trunc_good) else $error("check on good readback"); // [R14]

  property p_mismatch;
    @(posedge clock_i) disable iff (sys_rst_i)
      (done_o && st_r.sent != 16'h0000 && st_r.ret_fmt != st_r.req_fmt)
        |-> (sense_key_o == SK_RECOVERED && sense_asc_o == ASC_DEFECT_NF);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch sense wrong"); // [R8]

  property p_hdr_flags;
    @(posedge clock_i) disable iff (sys_rst_i)
      (st_r.st == RD_HDR && din_valid_o && st_r.sent == 16'h0001)
        |-> din_data_o == {3'h0, st_r.plist, st_r.glist, use_fmt};
  endproperty
  a_hdr_flags: assert property (p_hdr_flags) else $error("header flags wrong"); // [R10] [R11]

  property p_no_list;
    @(posedge clock_i) disable iff (sys_rst_i)
      (st_r.st == RD_LIST) |-> (st_r.plist || st_r.glist);
  endproperty
  a_no_list: assert property (p_no_list) else $error("descriptors without select"); // [R6]

  sequence s_fault_end;
    (st_r.st == RD_CDB && cdb_valid_i && st_r.idx == 4'h9
      && st_r.opc == OPC_READ_DEFECT && fault);
  endsequence
  property p_fault;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_fault_end |-> ##2 (done_o && sense_key_o == SK_MEDIUM_ERR && !din_valid_o);
  endproperty
  a_fault: assert property (p_fault) else $error("medium fault not reported"); // [R2]

  property p_len;
    @(posedge clock_i) disable iff (sys_rst_i)
      (st_r.st == RD_LIST) |-> st_r.list_len ==
        ((st_r.plist ? plist_bytes_i : 16'h0000) + (st_r.glist ? glist_bytes_i : 16'h0000));
  endproperty
  a_len: assert property (p_len) else $error("list length wrong"); // [R13]

  property p_order;
    @(posedge clock_i) disable iff (sys_rst_i)
      (store_rd_o && !st_r.in_glist) |-> st_r.plist;
  endproperty
  a_order: assert property (p_order) else $error("primary read when not selected"); // [R3] [R5]
endmodule : rdd_readback
`default_nettype wire

// [rdd_store_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rdd_store_model (
  input  wire logic        store_rd_i,
  input  wire logic        store_glist_i,
  input  wire logic [15:0] store_addr_i,
  output logic [7:0]       store_data_o
);
  // Byte valid only while the read strobe stands, inverted otherwise
  assign store_data_o = (store_addr_i[7:0] ^ (store_glist_i ? 8'hc3 : 8'h3c))
                      ^ {8{~store_rd_i}};
endmodule : rdd_store_model
`default_nettype wire

// [rdd_readback_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module rdd_readback_tb;
  import rdd_pkg::*;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cdb_valid_i = 1'b0;
  logic [7:0]  cdb_byte_i = 8'h00;
  logic        cdb_ready_o;
  logic        store_avail_i = 1'b1;
  logic        store_fault_i = 1'b0;
  logic        fmt_bfi_ok_i = 1'b1;
  logic        fmt_phys_ok_i = 1'b0;
  logic        fmt_block_ok_i = 1'b0;
  logic [2:0]  fmt_default_i = FMT_BFI;
  logic [15:0] plist_bytes_i = 16'h0010;
  logic [15:0] glist_bytes_i = 16'h0008;
  logic        store_rd_o, store_glist_o, din_valid_o, done_o;
  logic [2:0]  store_fmt_o;
  logic [15:0] store_addr_o;
  logic [7:0]  store_data_i, din_data_o, status_o, sense_asc_o;
  logic        din_ready_i = 1'b1;
  logic [3:0]  sense_key_o;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          seed = 57712;
  logic [2:0]  dflt [3] = '{FMT_BLOCK, FMT_BFI, FMT_PHYS};

  always #5 clock_i = ~clock_i;

  rdd_readback rdd_readback_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .cdb_valid_i(cdb_valid_i), .cdb_byte_i(cdb_byte_i), .cdb_ready_o(cdb_ready_o),
    .store_avail_i(store_avail_i), .store_fault_i(store_fault_i),
    .fmt_bfi_ok_i(fmt_bfi_ok_i), .fmt_phys_ok_i(fmt_phys_ok_i),
    .fmt_block_ok_i(fmt_block_ok_i), .fmt_default_i(fmt_default_i),
    .plist_bytes_i(plist_bytes_i), .glist_bytes_i(glist_bytes_i),
    .store_rd_o(store_rd_o), .store_glist_o(store_glist_o), .store_fmt_o(store_fmt_o),
    .store_addr_o(store_addr_o), .store_data_i(store_data_i), .din_valid_o(din_valid_o),
    .din_data_o(din_data_o), .din_ready_i(din_ready_i), .done_o(done_o),
    .status_o(status_o), .sense_key_o(sense_key_o), .sense_asc_o(sense_asc_o));

  rdd_store_model rdd_store_model_inst (.store_rd_i(store_rd_o),
    .store_glist_i(store_glist_o), .store_addr_i(store_addr_o), .store_data_o(store_data_i));

  task automatic results;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic cmp_len(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t byte count %h expected %h", $time, got, exp);
    end
  endtask : cmp_len

  task automatic cmp_byte(logic [7:0] got, logic [7:0] exp, int idx);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t data byte %0d %h expected %h", $time, idx, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_stat(logic [20:0] got, logic [20:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t done/status/sense %h expected %h", $time, got, exp);
    end
  endtask : cmp_stat

  function automatic logic [2:0] used_fmt(logic [2:0] rf);
    logic ok;
    ok = (rf == FMT_BFI && fmt_bfi_ok_i) || (rf == FMT_PHYS && fmt_phys_ok_i)
      || (rf == FMT_BLOCK && fmt_block_ok_i);
    return ok ? rf : fmt_default_i;
  endfunction : used_fmt

  function automatic logic [7:0] exp_byte(int i, logic p, logic g, logic [2:0] f,
                                          logic [15:0] len);
    logic [15:0] k;
    k = 16'(i - 4);
    if (i == 0) return 8'h00;
    if (i == 1) return {3'h0, p, g, f};
    if (i == 2) return len[15:8];
    if (i == 3) return len[7:0];
    if (p && k < plist_bytes_i) return k[7:0] ^ 8'h3c;
    if (p) k = k - plist_bytes_i;
    return k[7:0] ^ 8'hc3;
  endfunction : exp_byte

  // Issue one command as initiator and judge everything that came back
  task automatic run(logic [7:0] opc, logic p, logic g, logic [2:0] rf, logic [15:0] alloc);
    logic [7:0]  cdb [10];
    logic [7:0]  q [$];
    logic [2:0]  uf;
    logic [15:0] len, tot;
    logic [19:0] st;
    logic        done;
    int          n;
    cdb = '{opc, 8'h00, {3'h0, p, g, rf}, 8'h00, 8'h00, 8'h00, 8'h00,
            alloc[15:8], alloc[7:0], 8'h00};
    for (int i = 0; i < CDB_LEN; i++) begin
      cdb_valid_i <= 1'b1;
      cdb_byte_i  <= cdb[i];
      n = 0;
      @(negedge clock_i);
      while (cdb_ready_o !== 1'b1 && n < 100) begin
        n++;
        @(negedge clock_i);
      end
      @(posedge clock_i);
    end
    cdb_valid_i <= 1'b0;
    done = 1'b0;
    n = 0;
    while (!done && n < 3000) begin
      @(negedge clock_i);
      n++;
      if (din_valid_o === 1'b1 && din_ready_i === 1'b1) q.push_back(din_data_o);
      if (done_o === 1'b1) begin
        done = 1'b1;
      end else begin
        @(posedge clock_i);
        din_ready_i <= 1'($random(seed));
      end
    end
    @(posedge clock_i);
    uf  = used_fmt(rf);
    len = (p ? plist_bytes_i : 16'h0000) + (g ? glist_bytes_i : 16'h0000);
    tot = (opc != OPC_READ_DEFECT || !store_avail_i) ? 16'h0000
        : (alloc < HDR_LEN + len ? alloc : HDR_LEN + len);
    if (opc != OPC_READ_DEFECT) st = {ST_CHECK, SK_ILLEGAL, ASC_BAD_OPC};
    else if (!store_avail_i) st = {ST_CHECK, store_fault_i ? SK_MEDIUM_ERR : SK_NO_SENSE,
                                   ASC_DEFECT_NF};
    else if (uf != rf) st = {ST_CHECK, SK_RECOVERED, ASC_DEFECT_NF};
    else st = {ST_GOOD, SK_NO_SENSE, ASC_NONE};
    cmp_stat({done, status_o, sense_key_o, sense_asc_o}, {1'b1, st});
    cmp_len(16'(q.size()), tot);
    if (opc == OPC_READ_DEFECT && store_avail_i) cmp_byte({5'h0, store_fmt_o}, {5'h0, uf}, 1);
    for (int i = 0; i < q.size(); i++) begin
      cmp_byte(q[i], exp_byte(i, p, g, uf, len), i);
    end
    // Initiator side: partial-list detection from the reported list length
    if (q.size() >= 4 && alloc < HDR_LEN + len) cmp_len({q[2], q[3]}, len);
  endtask : run

  initial begin
    #800000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end

  initial begin
    logic [2:0]  rf, df;
    logic [15:0] alloc, dsz;
    logic        p, g;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    run(8'h28, 1'b1, 1'b1, FMT_BFI, 16'h0040);
    store_avail_i <= 1'b0;
    store_fault_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    run(OPC_READ_DEFECT, 1'b1, 1'b0, FMT_BFI, 16'h0040);
    store_fault_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    run(OPC_READ_DEFECT, 1'b1, 1'b1, FMT_BFI, 16'h0040);
    store_avail_i <= 1'b1;
    for (int t = 0; t < 48; t++) begin
      df = dflt[{$random(seed)} % 3];
      fmt_default_i  <= df;
      fmt_bfi_ok_i   <= 1'($random(seed)) | (df == FMT_BFI);
      fmt_phys_ok_i  <= 1'($random(seed)) | (df == FMT_PHYS);
      fmt_block_ok_i <= 1'($random(seed)) | (df == FMT_BLOCK);
      rf    = (t % 8 == 3) ? 3'h6 : 3'($random(seed));
      p     = (t % 8 == 0) ? 1'b0 : 1'($random(seed));
      g     = (t % 8 == 0) ? 1'b0 : 1'($random(seed));
      alloc = (t % 8 == 1) ? HDR_LEN : (t % 8 == 2) ? 16'h0000 : 16'({$random(seed)} % 90);
      repeat (3) @(posedge clock_i);
      dsz = (used_fmt(rf) == FMT_BLOCK) ? SHORT_DESC : LONG_DESC;
      plist_bytes_i <= dsz * 16'({$random(seed)} % 6);
      glist_bytes_i <= dsz * 16'({$random(seed)} % 6);
      @(posedge clock_i);
      run(OPC_READ_DEFECT, p, g, rf, alloc);
    end
    results();
  end
endmodule : rdd_readback_tb
`default_nettype wire
